/* src/pps_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - each buck and each ldo has its own pin enable input.
// - filtered trigger rising edge starts the timed power-on sequence.
// - trigger input is deglitched for 1 ms before edges count.
// - filtered trigger falling edge starts the timed shutdown sequence.
// - pin enable changes are ignored while the trigger is high.
// - regulator on equals bus enable and (pin enable or sequenced trigger).
// - bus enable bits reset to on.
// - turn-on delays 1, 1.5, 2, 3, 6, 11 ms; defaults 1.5/2/3/6.
// - turn-off delays 0, 0.5, 1, 2, 5, 10 ms; defaults as on.
// - power-good pulled low while buck levels are not good.
// - power-good release delay 50 us, 50, 100, 200 ms; default 50 ms.
// - level-ok flags come from trimmed comparators with hysteresis.
// - enabled buck level-ok rise starts delay; power-good low until done.
// - other channel set events do not disturb a running delay.
// - any enabled level-ok fall drops power-good and restarts delay.
// - late buck enable starts 5 ms mask holding power-good high.
// - late buck still not ok at mask expiry drops power-good.
// - delay timer cleared by reset or enables, set by enable and ok.
// - power-good is timer output ANDed with both mask outputs.
// - supply below lockout forces all four regulator enables off.
module pps_top #(
	parameter int TICK_CYCLES = pps_pkg::TICK_CYC
)(
	// clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        sys_rst,
	// register port
	input  wire logic [pps_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [pps_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [pps_pkg::DATA_W-1:0]  reg_rdata,
	// enable pins
	input  wire logic                        buck1_pin_enable,
	input  wire logic                        buck2_pin_enable,
	input  wire logic                        ldo1_pin_enable,
	input  wire logic                        ldo2_pin_enable,
	input  wire logic                        seq_trigger_pin,
	// analog status flags
	input  wire logic                        buck1_level_ok,
	input  wire logic                        buck2_level_ok,
	input  wire logic                        raw_input_supply_ok,
	// regulator enables
	output logic                             buck1_enable,
	output logic                             buck2_enable,
	output logic                             ldo1_enable,
	output logic                             ldo2_enable,
	// open-drain power-good pin
	output logic                             power_good_out_o,
	output logic                             power_good_out_oe
);
	import pps_pkg::*;

	// turn-on delay code to ticks
	function automatic logic [SEQ_CNT_W-1:0] on_ticks(input logic [CODE_W-1:0] code);
		int us;
		case (code)
			4'h0: us = ON_US_0;
			4'h1: us = ON_US_1;
			4'h2: us = ON_US_2;
			4'h3: us = ON_US_3;
			4'h4: us = ON_US_4;
			default: us = ON_US_5;
		endcase
		return SEQ_CNT_W'(us / TICK_US);
	endfunction

	// turn-off delay code to ticks
	function automatic logic [SEQ_CNT_W-1:0] off_ticks(input logic [CODE_W-1:0] code);
		int us;
		us = OFF_US_5;
		case (code)
			4'h0: us = OFF_US_0;
			4'h1: us = OFF_US_1;
			4'h2: us = OFF_US_2;
			4'h3: us = OFF_US_3;
			4'h4: us = OFF_US_4;
			4'h6: us = OFF_US_6;
			4'h7: us = OFF_US_7;
			4'h8: us = OFF_US_8;
			default: us = OFF_US_5;
		endcase
		return SEQ_CNT_W'(us / TICK_US);
	endfunction

	// power-good delay select to ticks
	function automatic logic [PG_CNT_W-1:0] pg_ticks(input logic [1:0] sel);
		int us;
		us = PG_US_1;
		case (sel)
			2'h0: us = PG_US_0;
			2'h1: us = PG_US_1;
			2'h2: us = PG_US_2;
			default: us = PG_US_3;
		endcase
		return PG_CNT_W'(us / TICK_US);
	endfunction

	// synchroniser stages for all asynchronous inputs
	logic [7:0]             sync1_reg;
	logic [7:0]             sync2_reg;
	wire  [7:0]             async_in;
	wire  [3:0]             pin_s;
	wire                    trig_s;
	wire                    ok1_s;
	wire                    ok2_s;
	wire                    supply_s;

	// timebase
	logic [TICK_W-1:0]      tick_cnt_reg;
	wire                    tick;

	// trigger deglitch
	logic [DG_CNT_W-1:0]    dg_cnt_reg;
	logic                   trig_f_reg;
	wire                    trig_flip;
	wire                    trig_rise;
	wire                    trig_fall;

	// software registers
	logic [3:0]             bus_en_reg;
	logic [DATA_W-1:0]      on_code_reg;
	logic [DATA_W-1:0]      off_code_reg;
	logic [1:0]             pg_sel_reg;
	logic [DATA_W-1:0]      rdata_reg;
	logic [DATA_W-1:0]      rdata_next;
	logic [DATA_W-1:0]      status_w;

	// sequencer
	pps_seq_t               seq_dir_reg;
	logic [SEQ_CNT_W-1:0]   seq_cnt_reg;
	logic [3:0]             seq_on_reg;
	logic [3:0]             seq_on_next;
	logic [3:0]             pin_hold_reg;
	wire  [3:0]             pin_eff;
	logic [3:0]             reg_on_reg;
	wire  [3:0]             reg_on_next;

	// power-good logic
	pps_pg_t                pg_state_reg;
	logic [PG_CNT_W-1:0]    pg_cnt_reg;
	logic [1:0]             chan_d_reg;
	logic [1:0]             ok_d_reg;
	logic [1:0]             en_d_reg;
	logic [1:0]             mask_act_reg;
	logic [MSK_CNT_W-1:0]   mask_cnt_reg [2];
	logic                   pg_low_reg;
	wire  [1:0]             buck_en;
	wire  [1:0]             buck_ok;
	wire  [1:0]             chan_set;
	wire                    set_rise;
	wire                    ok_fall;
	wire                    pg_clear;
	wire  [PG_CNT_W-1:0]    pg_target;
	wire  [1:0]             mask_out;
	wire  [1:0]             mask_start = buck_en & ~en_d_reg & {2{pg_state_reg == PG_DONE}};
	wire                    pg_next;

	// input synchronisers, two flops each
	assign async_in = {raw_input_supply_ok, buck2_level_ok, buck1_level_ok, seq_trigger_pin,
		ldo2_pin_enable, ldo1_pin_enable, buck2_pin_enable, buck1_pin_enable};
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_reg <= 8'h00;
			sync2_reg <= 8'h00;
		end else begin
			sync1_reg <= async_in;
			sync2_reg <= sync1_reg;
		end
	end
	assign pin_s    = sync2_reg[3:0];
	assign trig_s   = sync2_reg[4];
	assign ok1_s    = sync2_reg[5];
	assign ok2_s    = sync2_reg[6];
	assign supply_s = sync2_reg[7];

	// free-running tick divider
	assign tick = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			tick_cnt_reg <= '0;
		else if (tick)
			tick_cnt_reg <= '0;
		else
			tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
	end

	// trigger filter: flips only after a full deglitch time of disagreement
	assign trig_flip = (trig_s != trig_f_reg) && tick && (dg_cnt_reg == DG_CNT_W'(DEGLITCH_TK - 1));
	assign trig_rise = trig_flip && !trig_f_reg;
	assign trig_fall = trig_flip && trig_f_reg;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			dg_cnt_reg <= '0;
			trig_f_reg <= 1'b0;
		end else if (trig_s == trig_f_reg || trig_flip) begin
			dg_cnt_reg <= '0;
			trig_f_reg <= trig_f_reg ^ trig_flip;
		end else if (tick) begin
			dg_cnt_reg <= dg_cnt_reg + DG_CNT_W'(1);
		end
	end

	// register writes
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			bus_en_reg   <= RST_ENABLE;
			on_code_reg  <= RST_ON_DLY;
			off_code_reg <= RST_OFF_DLY;
			pg_sel_reg   <= RST_PG_SEL;
		end else if (reg_wr) begin
			case (reg_addr)
				OFS_ENABLE:  bus_en_reg   <= reg_wdata[3:0];
				OFS_ON_DLY:  on_code_reg  <= reg_wdata;
				OFS_OFF_DLY: off_code_reg <= reg_wdata;
				OFS_PG_CFG:  pg_sel_reg   <= reg_wdata[1:0];
				default: ;
			endcase
		end
	end

	// status word and read mux
	always_comb begin
		status_w = '0;
		status_w[ST_REG_ON +: 4] = reg_on_reg;
		status_w[ST_PG]       = !pg_low_reg;
		status_w[ST_TRIG]     = trig_f_reg;
		status_w[ST_SUPPLY]   = supply_s;
		status_w[ST_OK1]      = ok1_s;
		status_w[ST_OK2]      = ok2_s;
		status_w[ST_PG_RUN]   = (pg_state_reg == PG_RUN);
		status_w[ST_PG_DONE]  = (pg_state_reg == PG_DONE);
		status_w[ST_SEQ_UP]   = (seq_dir_reg == SEQ_UP);
		status_w[ST_SEQ_DOWN] = (seq_dir_reg == SEQ_DOWN);
		status_w[ST_MASK +: 2] = mask_act_reg;
		rdata_next = '0;
		if (reg_rd) begin
			case (reg_addr)
				OFS_ENABLE:  rdata_next = {12'h000, bus_en_reg};
				OFS_ON_DLY:  rdata_next = on_code_reg;
				OFS_OFF_DLY: rdata_next = off_code_reg;
				OFS_PG_CFG:  rdata_next = {14'h0000, pg_sel_reg};
				OFS_STATUS:  rdata_next = status_w;
				default:     rdata_next = '0;
			endcase
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			rdata_reg <= '0;
		else
			rdata_reg <= rdata_next;
	end
	assign reg_rdata = rdata_reg;

	// sequencer direction and elapsed tick count since last filtered edge
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			seq_dir_reg <= SEQ_IDLE;
			seq_cnt_reg <= '0;
		end else if (trig_rise) begin
			seq_dir_reg <= SEQ_UP;
			seq_cnt_reg <= '0;
		end else if (trig_fall) begin
			seq_dir_reg <= SEQ_DOWN;
			seq_cnt_reg <= '0;
		end else if (tick && seq_cnt_reg != '1) begin
			seq_cnt_reg <= seq_cnt_reg + SEQ_CNT_W'(1);
		end
	end

	// per-regulator sequenced enable after its own delay
	always_comb begin
		seq_on_next = seq_on_reg;
		for (int i = 0; i < NUM_REG; i++) begin
			case (seq_dir_reg)
				SEQ_UP:
					if (seq_cnt_reg >= on_ticks(on_code_reg[i*CODE_W +: CODE_W]))
						seq_on_next[i] = 1'b1;
				SEQ_DOWN:
					if (seq_cnt_reg >= off_ticks(off_code_reg[i*CODE_W +: CODE_W]))
						seq_on_next[i] = 1'b0;
				default: seq_on_next[i] = 1'b0;
			endcase
		end
	end

	// pins are frozen while the trigger is high; pins held low leave control to the sequence
	assign pin_eff     = trig_f_reg ? pin_hold_reg : pin_s;
	assign reg_on_next = {4{supply_s}} & bus_en_reg & (pin_eff | seq_on_reg);
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			seq_on_reg   <= 4'h0;
			pin_hold_reg <= 4'h0;
			reg_on_reg   <= 4'h0;
		end else begin
			seq_on_reg   <= seq_on_next;
			pin_hold_reg <= pin_eff;
			reg_on_reg   <= reg_on_next;
		end
	end
	assign buck1_enable = reg_on_reg[IDX_BUCK1];
	assign buck2_enable = reg_on_reg[IDX_BUCK2];
	assign ldo1_enable  = reg_on_reg[IDX_LDO1];
	assign ldo2_enable  = reg_on_reg[IDX_LDO2];

	// power-good set, clear and restart conditions
	assign buck_en   = reg_on_reg[1:0];
	assign buck_ok   = {ok2_s, ok1_s};
	assign chan_set  = buck_en & buck_ok;
	assign set_rise  = |(chan_set & ~chan_d_reg);
	assign ok_fall   = |(ok_d_reg & ~buck_ok & buck_en);
	assign pg_clear  = ~|buck_en;
	assign pg_target = pg_ticks(pg_sel_reg);

	// delay timer; clear has priority so set and clear never act together
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pg_state_reg <= PG_CLEAR;
			pg_cnt_reg   <= '0;
		end else if (pg_clear) begin
			pg_state_reg <= PG_CLEAR;
			pg_cnt_reg   <= '0;
		end else if (ok_fall) begin
			pg_state_reg <= PG_RUN;
			pg_cnt_reg   <= '0;
		end else begin
			case (pg_state_reg)
				PG_CLEAR:
					if (set_rise) begin
						pg_state_reg <= PG_RUN;
						pg_cnt_reg   <= '0;
					end
				PG_RUN:
					if (tick) begin  // set events from either channel ignored here
						if (pg_cnt_reg >= pg_target - PG_CNT_W'(1))
							pg_state_reg <= PG_DONE;
						else
							pg_cnt_reg <= pg_cnt_reg + PG_CNT_W'(1);
					end
				PG_DONE: ;
				default: pg_state_reg <= PG_CLEAR;
			endcase
		end
	end

	// mask windows started by a late buck enable
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			mask_act_reg    <= 2'b00;
			mask_cnt_reg[0] <= '0;
			mask_cnt_reg[1] <= '0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (!buck_en[i]) begin
					mask_act_reg[i] <= 1'b0;
				end else if (mask_start[i]) begin
					mask_act_reg[i] <= 1'b1;
					mask_cnt_reg[i] <= '0;
				end else if (mask_act_reg[i] && tick) begin
					if (mask_cnt_reg[i] == MSK_CNT_W'(MASK_TK - 1))
						mask_act_reg[i] <= 1'b0;
					else
						mask_cnt_reg[i] <= mask_cnt_reg[i] + MSK_CNT_W'(1);
				end
			end
		end
	end

	// final gate: timer done and each channel masked, ok, or not enabled
	assign mask_out = ~buck_en | mask_start | mask_act_reg | buck_ok;
	assign pg_next  = (pg_state_reg == PG_DONE) & mask_out[0] & mask_out[1];

	// edge history and the registered power-good pull-down
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			chan_d_reg <= 2'b00;
			ok_d_reg   <= 2'b00;
			en_d_reg   <= 2'b00;
			pg_low_reg <= 1'b1;
		end else begin
			chan_d_reg <= chan_set;
			ok_d_reg   <= buck_ok;
			en_d_reg   <= buck_en;
			pg_low_reg <= !pg_next;
		end
	end

	// open drain: only ever pulls low
	assign power_good_out_o  = 1'b0;
	assign power_good_out_oe = pg_low_reg;

endmodule
`default_nettype wire

/* src/pps_pkg.sv */
// shared constants for the power sequencer and power-good logic
package pps_pkg;

	// register port geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;

	// register word indices
	localparam logic [ADDR_W-1:0] OFS_ENABLE  = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_ON_DLY  = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_OFF_DLY = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_PG_CFG  = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_STATUS  = 4'h4;

	// regulator index order inside every 4-bit vector
	localparam int IDX_BUCK1 = 0;
	localparam int IDX_BUCK2 = 1;
	localparam int IDX_LDO1  = 2;
	localparam int IDX_LDO2  = 3;
	localparam int NUM_REG   = 4;
	localparam int CODE_W    = 4;

	// reset values of the software registers
	localparam logic [3:0]        RST_ENABLE  = 4'hF;
	localparam logic [DATA_W-1:0] RST_ON_DLY  = 16'h4321;
	localparam logic [DATA_W-1:0] RST_OFF_DLY = 16'h8736;
	localparam logic [1:0]        RST_PG_SEL  = 2'h1;

	// status word field positions
	localparam int ST_REG_ON   = 0;
	localparam int ST_PG       = 4;
	localparam int ST_TRIG     = 5;
	localparam int ST_SUPPLY   = 6;
	localparam int ST_OK1      = 7;
	localparam int ST_OK2      = 8;
	localparam int ST_PG_RUN   = 9;
	localparam int ST_PG_DONE  = 10;
	localparam int ST_SEQ_UP   = 11;
	localparam int ST_SEQ_DOWN = 12;
	localparam int ST_MASK     = 13;

	// timebase: clock rate and tick period
	localparam int CLK_HZ      = 40000000;
	localparam int TICK_US     = 50;
	localparam int TICK_CYC    = (CLK_HZ / 1000000) * TICK_US;

	// times in microseconds, converted to ticks
	localparam int DEGLITCH_US = 1000;
	localparam int MASK_US     = 5000;
	localparam int DEGLITCH_TK = DEGLITCH_US / TICK_US;
	localparam int MASK_TK     = MASK_US / TICK_US;

	// turn-on delay choices (us)
	localparam int ON_US_0 = 1000;
	localparam int ON_US_1 = 1500;
	localparam int ON_US_2 = 2000;
	localparam int ON_US_3 = 3000;
	localparam int ON_US_4 = 6000;
	localparam int ON_US_5 = 11000;

	// turn-off delay choices (us); codes 6..8 carry the 1.5, 3 and 6 ms default values
	localparam int OFF_US_0 = 0;
	localparam int OFF_US_1 = 500;
	localparam int OFF_US_2 = 1000;
	localparam int OFF_US_3 = 2000;
	localparam int OFF_US_4 = 5000;
	localparam int OFF_US_5 = 10000;
	localparam int OFF_US_6 = 1500;
	localparam int OFF_US_7 = 3000;
	localparam int OFF_US_8 = 6000;

	// power-good release delay choices (us)
	localparam int PG_US_0 = 50;
	localparam int PG_US_1 = 50000;
	localparam int PG_US_2 = 100000;
	localparam int PG_US_3 = 200000;

	// counter widths
	localparam int SEQ_CNT_W = 9;
	localparam int PG_CNT_W  = 12;
	localparam int DG_CNT_W  = 5;
	localparam int MSK_CNT_W = 7;
	localparam int TICK_W    = 12;

	// state types
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_UP, SEQ_DOWN} pps_seq_t;
	typedef enum logic [1:0] {PG_CLEAR, PG_RUN, PG_DONE} pps_pg_t;

endpackage

/* testbench/pps_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module pps_checker
	import pps_pkg::*;
#(
	parameter int TICK_CYCLES = pps_pkg::TICK_CYC
)(
	// clock and reset
	input wire logic                        clk_sys,
	input wire logic                        sys_rst,
	// register port
	input wire logic                        reg_rd,
	input wire logic [pps_pkg::DATA_W-1:0]  reg_rdata,
	// pins and flags
	input wire logic                        buck1_pin_enable,
	input wire logic                        seq_trigger_pin,
	input wire logic                        buck1_level_ok,
	input wire logic                        buck2_level_ok,
	input wire logic                        raw_input_supply_ok,
	// regulator enables and power good
	input wire logic                        buck1_enable,
	input wire logic                        buck2_enable,
	input wire logic                        ldo1_enable,
	input wire logic                        ldo2_enable,
	input wire logic                        power_good_out_o,
	input wire logic                        power_good_out_oe
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	// enable vector and power-good set terms
	wire logic [3:0] en_v = {ldo2_enable, ldo1_enable, buck2_enable, buck1_enable};
	wire logic       set1 = buck1_enable & buck1_level_ok;
	wire logic       set2 = buck2_enable & buck2_level_ok;
	int              trig_cnt_reg;

	// cycles the raw trigger has stayed high
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) trig_cnt_reg <= 0;
		else trig_cnt_reg <= seq_trigger_pin ? trig_cnt_reg + 1 : 0;
	end

	uvlo_gate_a: assert property ((!raw_input_supply_ok) [*4] |-> en_v == 4'h0)
		else $error("enable on while supply low");
	supply_rise_a: assert property (|(en_v & ~$past(en_v)) |-> $past(raw_input_supply_ok, 3))
		else $error("enable rose without supply");
	od_data_a: assert property (power_good_out_o == 1'b0)
		else $error("power good data not low");
	both_off_a: assert property ((!buck1_enable && !buck2_enable) [*4] |-> power_good_out_oe)
		else $error("power good with both bucks off");
	ok_fall_a: assert property (((buck1_enable && $fell(buck1_level_ok)) ||
		(buck2_enable && $fell(buck2_level_ok))) |-> ##[1:6] power_good_out_oe)
		else $error("level fall kept power good");
	pg_cause_a: assert property ($fell(power_good_out_oe) |-> set1 || set2)
		else $error("power good released without a ready buck");
	buck1_cause_a: assert property ($rose(buck1_enable) |->
		$past(buck1_pin_enable, 3) || trig_cnt_reg >= 30 * TICK_CYCLES)
		else $error("buck1 on without pin or trigger");
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside read cycle");
endmodule

bind pps_top pps_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.clk_sys, .sys_rst, .reg_rd, .reg_rdata, .buck1_pin_enable, .seq_trigger_pin,
	.buck1_level_ok, .buck2_level_ok, .raw_input_supply_ok, .buck1_enable,
	.buck2_enable, .ldo1_enable, .ldo2_enable, .power_good_out_o, .power_good_out_oe
);
`default_nettype wire

/* testbench/pps_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pps_host_model (
	// open-drain power-good pin
	input  wire logic power_good_out_o,
	input  wire logic power_good_out_oe,
	// host side
	output logic      pg_line,
	output logic      host_in_reset
);
	// pull-up wins when the device lets go of the line
	assign pg_line       = power_good_out_oe ? power_good_out_o : 1'b1;
	assign host_in_reset = !pg_line;
endmodule
`default_nettype wire

/* testbench/pps_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pps_top_tb;
	import pps_pkg::*;
	localparam int TK = 4;
	typedef struct {logic [3:0] a; logic [15:0] w; logic [3:0] p; logic [15:0] r; logic [3:0] e;} pps_row_t;
	// design inputs and outputs
	logic              clk_sys   = 1'b0;
	logic              sys_rst   = 1'b1;
	logic [ADDR_W-1:0] reg_addr  = 4'h0;
	logic [DATA_W-1:0] reg_wdata = 16'h0000;
	logic              reg_wr    = 1'b0;
	logic              reg_rd    = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic [3:0]        pin       = 4'h0;
	logic              trig      = 1'b0;
	logic [1:0]        ok        = 2'h0;
	logic              sup       = 1'b1;
	logic [3:0]        en;
	logic              pg_o;
	logic              pg_oe;
	logic              pg_line;
	logic              host_rst;
	int                n_fail      = 0;
	int                checks_done = 0;
	int                cyc         = 0;
	int                on_tk[16]   = '{0: 20, 1: 30, 2: 40, 3: 60, 4: 120, default: 220};
	int                off_tk[16]  = '{0: 0, 1: 10, 2: 20, 3: 40, 4: 100, 5: 200, 6: 30, 7: 60, 8: 120, default: 200};
	int                pg_tk[4]    = '{1, 1000, 2000, 4000};
	pps_row_t          rows[9]     = '{
		'{OFS_ENABLE, 16'h000F, 4'h1, 16'h000F, 4'h1},
		'{OFS_ENABLE, 16'h000F, 4'h2, 16'h000F, 4'h2},
		'{OFS_ENABLE, 16'h000F, 4'h4, 16'h000F, 4'h4},
		'{OFS_ENABLE, 16'h000F, 4'h8, 16'h000F, 4'h8},
		'{OFS_ENABLE, 16'hFFF5, 4'hF, 16'h0005, 4'h5},
		'{OFS_PG_CFG, 16'hFFFE, 4'hF, 16'h0002, 4'h5},
		'{OFS_STATUS, 16'hFFFF, 4'h0, 16'h0040, 4'h0},
		'{4'h9, 16'h1234, 4'h0, 16'h0000, 4'h0},
		'{OFS_ENABLE, 16'hFFFF, 4'h0, 16'h000F, 4'h0}
	};

	pps_top #(.TICK_CYCLES(TK)) DUT (
		.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.buck1_pin_enable(pin[0]), .buck2_pin_enable(pin[1]), .ldo1_pin_enable(pin[2]),
		.ldo2_pin_enable(pin[3]), .seq_trigger_pin(trig), .buck1_level_ok(ok[0]),
		.buck2_level_ok(ok[1]), .raw_input_supply_ok(sup), .buck1_enable(en[0]),
		.buck2_enable(en[1]), .ldo1_enable(en[2]), .ldo2_enable(en[3]),
		.power_good_out_o(pg_o), .power_good_out_oe(pg_oe)
	);
	pps_host_model u_host (.power_good_out_o(pg_o), .power_good_out_oe(pg_oe), .pg_line, .host_in_reset(host_rst));

	// clock and hang guard
	always #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 70000) begin
			n_fail++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk_v(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_t(input string nm, input int g, input int lo, input int hi);
		checks_done++;
		if (g < lo || g > hi) begin
			n_fail++;
			$display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask

	// register port cycles
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rchk(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		chk_v("read data", e, reg_rdata);
	endtask

	// first cycle each enable shows lvl, over a fixed span
	task automatic meas(input logic lvl, output int t[4]);
		int i;
		t = '{default: 0};
		for (int n = 1; n < 2000; n++) begin
			@(posedge clk_sys);
			for (i = 0; i < 4; i++) if (en[i] === lvl && t[i] == 0) t[i] = n;
		end
	endtask

	task automatic pg_wait(input logic lvl, output int n);
		for (n = 1; n < 20000 && pg_line !== lvl; n++) @(posedge clk_sys);
	endtask

	// timed power-up then power-down; pk pokes a pin mid-sequence
	task automatic seq_run(input logic [15:0] on_c, input logic [15:0] off_c, input bit pk);
		int t[4];
		int i;
		wr(OFS_ON_DLY, on_c);
		wr(OFS_OFF_DLY, off_c);
		trig <= 1'b1;
		fork
			meas(1'b1, t);
			if (pk) begin
				repeat (150) @(posedge clk_sys);
				pin[3] <= 1'b1;
			end
		join
		for (i = 0; i < 4; i++) chk_t("on delay", t[i], (18 + on_tk[on_c[4*i+:4]]) * TK, (21 + on_tk[on_c[4*i+:4]]) * TK + 6);
		pin[3] <= 1'b0;
		trig   <= 1'b0;
		meas(1'b0, t);
		for (i = 0; i < 4; i++) chk_t("off delay", t[i], (18 + off_tk[off_c[4*i+:4]]) * TK, (21 + off_tk[off_c[4*i+:4]]) * TK + 6);
		$display("sequence run done");
	endtask

	initial begin
		int n;
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rchk(OFS_ENABLE, 16'h000F);
		rchk(OFS_PG_CFG, 16'h0001);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			pin <= rows[i].p;
			repeat (5) @(posedge clk_sys);
			chk_v("enables", {12'h000, rows[i].e}, {12'h000, en});
			rchk(rows[i].a, rows[i].r);
		end
		$display("table done");
		// short trigger pulse must be filtered out
		pin  <= 4'h0;
		trig <= 1'b1;
		repeat (14 * TK) @(posedge clk_sys);
		rchk(OFS_STATUS, 16'h0040);
		trig <= 1'b0;
		repeat (400) @(posedge clk_sys);
		chk_v("glitch enables", 16'h0000, {12'h000, en});
		seq_run(RST_ON_DLY, RST_OFF_DLY, 1'b1);
		seq_run(16'h5050, 16'h4210, 1'b0);
		seq_run(16'h0000, 16'h5555, 1'b0);
		// supply lockout
		pin <= 4'hF;
		repeat (6) @(posedge clk_sys);
		sup <= 1'b0;
		repeat (8) @(posedge clk_sys);
		chk_v("lockout enables", 16'h0000, {12'h000, en});
		sup <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk_v("supply back", 16'h000F, {12'h000, en});
		$display("lockout done");
		// power-good delay for every code, other buck enabled mid-count
		pin   <= 4'h1;
		ok[1] <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(OFS_PG_CFG, 16'(i));
			ok[0] <= 1'b0;
			repeat (8) @(posedge clk_sys);
			chk_v("pg after fall", 16'h0000, 16'(pg_line));
			ok[0] <= 1'b1;
			fork
				pg_wait(1'b1, n);
				begin
					repeat (pg_tk[i] * TK / 2) @(posedge clk_sys);
					pin[1] <= 1'b1;
				end
			join
			chk_t("pg delay", n, (pg_tk[i] - 1) * TK - (i > 0 ? 8 : 0), (pg_tk[i] + 1) * TK + 8);
			pin[1] <= 1'b0;
		end
		$display("pg delay done");
		// late buck2 enable with level low, then high
		repeat (4) @(posedge clk_sys);
		ok[1] <= 1'b0;
		repeat (4) @(posedge clk_sys);
		pin[1] <= 1'b1;
		pg_wait(1'b0, n);
		chk_t("mask window", n, 99 * TK, 101 * TK + 8);
		ok[1] <= 1'b1;
		pg_wait(1'b1, n);
		chk_t("both ok", n, 1, 8);
		pin[1] <= 1'b0;
		repeat (8) @(posedge clk_sys);
		pin[1] <= 1'b1;
		repeat (120 * TK) @(posedge clk_sys);
		chk_v("pg late ok", 16'h0001, 16'(pg_line));
		$display("mask done");
		// second reset in mid-run
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk_v("reset enables", 16'h0000, {12'h000, en});
		chk_v("host reset", 16'h0001, 16'(host_rst));
		sys_rst <= 1'b0;
		rchk(OFS_ENABLE, 16'h000F);
		$display("reset done");
		close_out();
	end
endmodule
`default_nettype wire
